// ===== core/phy_power_irq_clock_out.sv
// power management, shared sleep or interrupt pin and mac reference clock
`timescale 1ns/1ps
module phy_power_irq_clock_out
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        reduced_pin,
  input  wire logic        rmii_mode,
  input  wire logic        rx_activity,
  input  wire logic [6:0]  event_in,
  input  wire logic [4:0]  reg_addr,
  input  wire logic        reg_write,
  input  wire logic [15:0] reg_wdata,
  output logic      [15:0] reg_rdata,
  input  wire logic        sleep_or_irq_pin_in,
  output logic             sleep_or_irq_pin_out,
  output logic             sleep_or_irq_pin_oe,
  output logic             mac_ref_clock_out,
  output logic             low_power,
  output logic             power_down
);
  typedef enum {pwr_normal, pwr_energy_sleep, pwr_down} power_state_e;

  power_state_e  state;
  power_state_e  next_state;
  logic [15:0]   energy_detect_control;
  logic [2:0]    irq_control_reg;
  logic [6:0]    unmask;
  logic [6:0]    event_flags;
  logic          pd_request;
  logic          pin_mode_irq;
  logic [15:0]   next_rdata;
  logic          wr_ed;
  logic          wr_ctl;
  logic          wr_stat;
  logic          wr_pwr;
  logic          rd_stat;
  logic          irq_allowed;
  logic          irq_pending;
  logic          pin_pd_req;
  logic          ed_enable;
  logic [6:0]    events_now;
  logic [6:0]    next_flags;
  logic          next_oe;
  logic          pd_cause;

  // address decode of management writes and reads
  function automatic logic hit(input logic [4:0] a, input logic [4:0] target);
    hit = (a == target);
  endfunction
  assign wr_ed   = reg_write & hit(reg_addr, phy_power_pkg::addr_energy_detect);
  assign wr_ctl  = reg_write & hit(reg_addr, phy_power_pkg::addr_irq_control) & ~reduced_pin;
  assign wr_stat = reg_write & hit(reg_addr, phy_power_pkg::addr_irq_status) & ~reduced_pin;
  assign wr_pwr  = reg_write & hit(reg_addr, phy_power_pkg::addr_power_control);
  assign rd_stat = ~reg_write & hit(reg_addr, phy_power_pkg::addr_irq_status);

  // interrupt plumbing, absent on the reduced-pin variant
  assign irq_allowed  = ~reduced_pin;
  assign pin_mode_irq = irq_allowed & irq_control_reg[phy_power_pkg::irq_oe_pos];
  assign ed_enable    = energy_detect_control[phy_power_pkg::ed_enable_pos];

  // events from the core plus energy wake; test bit raises every unmasked flag
  always_comb
  begin
    events_now = event_in;
    events_now[phy_power_pkg::energy_event_idx] = event_in[phy_power_pkg::energy_event_idx]
      | (state == pwr_energy_sleep & rx_activity);
    if (irq_control_reg[phy_power_pkg::irq_test_pos])
      events_now = '1;
  end

  // one sticky flag per event, cleared by a status read; a new event in that cycle wins
  for (genvar i = 0; i < phy_power_pkg::event_count; i++)
  begin : g_flag
    assign next_flags[i] = irq_allowed
                           & ((event_flags[i] & ~rd_stat) | (events_now[i] & unmask[i]));
  end

  assign irq_pending = irq_control_reg[phy_power_pkg::irq_enable_pos] & (|event_flags);

  // pin sampled as power-down request only in power-down pin mode, never on reduced part
  assign pin_pd_req = ~pin_mode_irq & irq_allowed & ~sleep_or_irq_pin_in;

  // register request or pin request, whichever comes
  assign pd_cause = pd_request | pin_pd_req;

  // power state selection; power-down outranks energy sleep
  always_comb
  begin
    next_state = state;
    case (state)
      pwr_normal:
        if (pd_cause)
          next_state = pwr_down;
        else if (ed_enable & ~rx_activity)
          next_state = pwr_energy_sleep;
      pwr_energy_sleep:
        if (pd_cause)
          next_state = pwr_down;
        else if (rx_activity | ~ed_enable)
          next_state = pwr_normal;
      pwr_down:
        if (~pd_cause)
          next_state = pwr_normal;
      default:
        next_state = pwr_normal;
    endcase
  end

  // register read mux; interrupt registers read as zero when reserved
  always_comb
  begin
    next_rdata = 16'h0000;
    case (reg_addr)
      phy_power_pkg::addr_energy_detect:
        next_rdata = energy_detect_control;
      phy_power_pkg::addr_irq_control:
        next_rdata = irq_allowed ? {13'h0000, irq_control_reg} : 16'h0000;
      phy_power_pkg::addr_irq_status:
        next_rdata = irq_allowed ? {1'b0, event_flags, 1'b0, unmask} : 16'h0000;
      phy_power_pkg::addr_power_control:
        next_rdata = {13'h0000, state == pwr_down, pin_mode_irq, pd_request};
      default:
        next_rdata = 16'h0000;
    endcase
  end

  // power state
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      state <= pwr_normal;
    else
      state <= next_state;
  end

  // sticky event flags
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      event_flags <= 7'h00;
    else
      event_flags <= next_flags;
  end

  // registered read data, one cycle after the address
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      reg_rdata <= 16'h0000;
    else
      reg_rdata <= next_rdata;
  end

  // energy detect control register
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      energy_detect_control <= phy_power_pkg::energy_detect_reset;
    else if (wr_ed)
      energy_detect_control <= reg_wdata;
  end

  // interrupt control register, writes ignored on the reduced-pin part
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      irq_control_reg <= phy_power_pkg::irq_control_reset;
    else if (wr_ctl)
      irq_control_reg <= reg_wdata[2:0];
  end

  // unmask half of the status register
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      unmask <= phy_power_pkg::unmask_reset;
    else if (wr_stat)
      unmask <= reg_wdata[6:0];
  end

  // software power-down request, the only way down on the reduced-pin part
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      pd_request <= 1'b0;
    else if (wr_pwr)
      pd_request <= reg_wdata[phy_power_pkg::pd_request_pos];
  end

  // open drain: only ever pulls low, released otherwise
  assign next_oe = pin_mode_irq & irq_pending;
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      sleep_or_irq_pin_oe <= 1'b0;
    else
      sleep_or_irq_pin_oe <= next_oe;
  end
  assign sleep_or_irq_pin_out = 1'b0;

  assign low_power  = (state == pwr_energy_sleep);
  assign power_down = (state == pwr_down);

  // reference clock for the mac, 25 or 50 mhz from the one core clock
  ref_clock_divider u_div
  (
    .clk         (clk),
    .rst         (rst),
    .rmii_mode   (rmii_mode),
    .ref_clk_out (mac_ref_clock_out)
  );
endmodule

// ===== core/phy_power_pkg.sv
// constants for the transceiver power, interrupt and clock-out block
package phy_power_pkg;
  // management register addresses
  localparam logic [4:0] addr_irq_control       = 5'h11;
  localparam logic [4:0] addr_irq_status        = 5'h12;
  localparam logic [4:0] addr_energy_detect     = 5'h1d;
  localparam logic [4:0] addr_power_control     = 5'h1e;
  // irq_control_reg fields
  localparam int irq_test_pos     = 2;
  localparam int irq_enable_pos   = 1;
  localparam int irq_oe_pos       = 0;
  // irq_status_reg fields
  localparam int event_lsb        = 8;
  localparam int event_count      = 7;
  localparam int energy_event_idx = 6;
  // energy_detect_control fields
  localparam int ed_enable_pos    = 15;
  // power control register fields
  localparam int pd_request_pos   = 0;
  localparam int pin_mode_pos     = 1;
  // reset values
  localparam logic [15:0] energy_detect_reset = 16'h0000;
  localparam logic [2:0]  irq_control_reset   = 3'h0;
  localparam logic [6:0]  unmask_reset        = 7'h00;
  // clock timing: 250 MHz core, 25 MHz and 50 MHz outputs
  localparam int clk_mhz       = 250;
  localparam int mii_ref_mhz   = 25;
  localparam int rmii_ref_mhz  = 50;
  localparam int mii_half      = clk_mhz / (2 * mii_ref_mhz);
  localparam int rmii_half     = clk_mhz / (2 * rmii_ref_mhz);
  localparam int mii_period    = clk_mhz / mii_ref_mhz;
  localparam int rmii_period   = clk_mhz / rmii_ref_mhz;
  localparam int div_width     = 4;
endpackage

// ===== core/ref_clock_divider.sv
// divider that makes the mac reference clock from the core clock
`timescale 1ns/1ps
module ref_clock_divider
(
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic rmii_mode,
  output logic      ref_clk_out
);
  logic [phy_power_pkg::div_width-1:0] count;
  logic [phy_power_pkg::div_width-1:0] next_count;
  logic [phy_power_pkg::div_width-1:0] last_count;
  logic [phy_power_pkg::div_width-1:0] low_len;
  logic                                wrap;

  // period and low phase pick 25 or 50 mhz; 50 mhz is 2 clocks high and 3 low,
  // since the core clock is only five times faster
  assign last_count = rmii_mode ? phy_power_pkg::div_width'(phy_power_pkg::rmii_period - 1)
                                : phy_power_pkg::div_width'(phy_power_pkg::mii_period - 1);
  assign low_len    = rmii_mode ? phy_power_pkg::div_width'(phy_power_pkg::rmii_period
                                                          - phy_power_pkg::rmii_half)
                                : phy_power_pkg::div_width'(phy_power_pkg::mii_period
                                                          - phy_power_pkg::mii_half);
  assign wrap       = (count >= last_count);
  assign next_count = wrap ? '0 : count + 1'b1;

  // count clocks of one period; output high for the last part of it
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      count       <= '0;
      ref_clk_out <= 1'b0;
    end
    else
    begin
      count       <= next_count;
      ref_clk_out <= (next_count >= low_len);
    end
  end
endmodule

// ===== test/host_pin_model.sv
// system side of the pulled-up shared pin
`timescale 1ns/1ps
module host_pin_model
(
  input  wire logic pull_low,
  input  wire logic oe,
  output logic      pin_level
);
  // open drain wire: any party low wins, else the pull-up
  assign pin_level = !(pull_low || oe);
endmodule

// ===== test/phy_power_irq_clock_out_assertions.sv
// port checker for the power, interrupt and clock-out block
`timescale 1ns/1ps
module power_checker
(
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        reduced_pin,
  input wire logic        rmii_mode,
  input wire logic        rx_activity,
  input wire logic [6:0]  event_in,
  input wire logic [4:0]  reg_addr,
  input wire logic        reg_write,
  input wire logic [15:0] reg_rdata,
  input wire logic        sleep_or_irq_pin_out,
  input wire logic        sleep_or_irq_pin_oe,
  input wire logic        mac_ref_clock_out,
  input wire logic        low_power
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // address classes and causes that may start an interrupt
  wire unmapped = !(reg_addr inside {5'h11, 5'h12, 5'h1d, 5'h1e});
  wire irq_addr = reg_addr == 5'h11 || reg_addr == 5'h12;
  wire cause    = |event_in || reg_write || (rx_activity && low_power);
  // high phase of the reference clock, then low
  sequence mii_high;
    mac_ref_clock_out [*5] ##1 !mac_ref_clock_out;
  endsequence
  sequence rmii_high;
    mac_ref_clock_out [*2] ##1 !mac_ref_clock_out;
  endsequence
  // low phase of the reference clock, then high
  sequence mii_low;
    !mac_ref_clock_out [*5] ##1 mac_ref_clock_out;
  endsequence
  sequence rmii_low;
    !mac_ref_clock_out [*3] ##1 mac_ref_clock_out;
  endsequence
  a_pin_drive_low: assert property (!sleep_or_irq_pin_out)
    else $error("shared pin driven high");
  a_oe_reduced_off: assert property (
    reduced_pin && $past(reduced_pin) |-> !sleep_or_irq_pin_oe) else $error("oe in reduced");
  a_oe_has_cause: assert property (
    $rose(sleep_or_irq_pin_oe) |-> $past(cause, 2) || $past(reg_write, 3))
    else $error("oe rose without cause");
  a_mii_period: assert property (
    $rose(mac_ref_clock_out) && !rmii_mode |-> mii_high) else $error("mii ref period");
  a_rmii_period: assert property (
    $rose(mac_ref_clock_out) && rmii_mode |-> rmii_high) else $error("rmii ref period");
  a_wake_on_rx: assert property (rx_activity |=> !low_power)
    else $error("low power during activity");
  a_unmapped_zero: assert property (
    !reg_write && unmapped |=> reg_rdata == 16'h0000) else $error("unmapped read");
  a_reduced_irq_read: assert property (
    reduced_pin && !reg_write && irq_addr |=> reg_rdata == 16'h0000) else $error("irq read");
  a_mii_low_phase: assert property (
    $fell(mac_ref_clock_out) && !rmii_mode |-> mii_low) else $error("mii ref low phase");
  a_rmii_low_phase: assert property (
    $fell(mac_ref_clock_out) && rmii_mode |-> rmii_low) else $error("rmii ref low phase");
endmodule

bind phy_power_irq_clock_out power_checker chk
(
  .clk                  (clk),
  .rst                  (rst),
  .reduced_pin          (reduced_pin),
  .rmii_mode            (rmii_mode),
  .rx_activity          (rx_activity),
  .event_in             (event_in),
  .reg_addr             (reg_addr),
  .reg_write            (reg_write),
  .reg_rdata            (reg_rdata),
  .sleep_or_irq_pin_out (sleep_or_irq_pin_out),
  .sleep_or_irq_pin_oe  (sleep_or_irq_pin_oe),
  .mac_ref_clock_out    (mac_ref_clock_out),
  .low_power            (low_power)
);

// ===== test/phy_power_irq_clock_out_bench.sv
// self-checking bench for the power, interrupt and clock-out block
`timescale 1ns/1ps
module phy_power_irq_clock_out_bench;
  logic        clk = 1'h0;
  logic        rst = 1'h1;
  logic        reduced_pin = 1'h0;
  logic        rmii_mode = 1'h0;
  logic        rx_activity = 1'h1;
  logic [6:0]  event_in = 7'h00;
  logic [4:0]  reg_addr = 5'h00;
  logic        reg_write = 1'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic [15:0] reg_rdata;
  logic        sleep_or_irq_pin_in, sleep_or_irq_pin_out, sleep_or_irq_pin_oe;
  logic        mac_ref_clock_out, low_power, power_down;
  logic        pull_low = 1'h0;
  int          miscompares = 0;
  int          comparisons = 0;
  int          cycles = 0;
  int          seed = 71477;
  int          model [int];
  phy_power_irq_clock_out dut
  (
    .clk                  (clk),
    .rst                  (rst),
    .reduced_pin          (reduced_pin),
    .rmii_mode            (rmii_mode),
    .rx_activity          (rx_activity),
    .event_in             (event_in),
    .reg_addr             (reg_addr),
    .reg_write            (reg_write),
    .reg_wdata            (reg_wdata),
    .reg_rdata            (reg_rdata),
    .sleep_or_irq_pin_in  (sleep_or_irq_pin_in),
    .sleep_or_irq_pin_out (sleep_or_irq_pin_out),
    .sleep_or_irq_pin_oe  (sleep_or_irq_pin_oe),
    .mac_ref_clock_out    (mac_ref_clock_out),
    .low_power            (low_power),
    .power_down           (power_down)
  );
  host_pin_model host (.pull_low(pull_low), .oe(sleep_or_irq_pin_oe),
    .pin_level(sleep_or_irq_pin_in));
  // one clock serves as the single reference in both modes
  initial forever #2 clk = ~clk;
  // run-length guard
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      miscompares++;
      summarize();
    end
  end
  task automatic summarize();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      miscompares++;
      $display("FAIL t=%0t seen %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // write strobe; the model drops irq writes in the reduced variant
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    tick(1);
    reg_addr = a;
    reg_wdata = d;
    reg_write = 1'h1;
    if (!(reduced_pin && (a == 5'h11 || a == 5'h12)))
      model[a] = d;
    tick(1);
    reg_write = 1'h0;
    reg_addr = 5'h00; // park unmapped so a held address does not keep reading status
  endtask
  task automatic rd(input logic [4:0] a);
    tick(1);
    reg_addr = a;
    tick(1);
    chk(reg_rdata, model.exists(a) ? 16'(model[a]) : 16'h0000);
    reg_addr = 5'h00;
  endtask
  // clock cycles from the first high sample of one reference clock pulse to the first high sample of the next
  task automatic ref_period(input int want);
    int n;
    n = 0;
    while (mac_ref_clock_out !== 1'h0) tick(1);
    while (mac_ref_clock_out !== 1'h1) tick(1);
    while (mac_ref_clock_out !== 1'h0)
    begin
      tick(1);
      n++;
    end
    while (mac_ref_clock_out !== 1'h1)
    begin
      tick(1);
      n++;
    end
    chk(16'(n), 16'(want));
  endtask
  initial
  begin
    tick(20);
    rst = 1'h0;
    wr(5'h1d, 16'($random(seed)) | 16'h8000);
    rd(5'h1d);
    rx_activity = 1'h0;
    tick(3);
    chk(low_power, 1'h1);
    rx_activity = 1'h1;
    tick(2);
    chk(low_power, 1'h0);
    ref_period(phy_power_pkg::clk_mhz / phy_power_pkg::mii_ref_mhz);
    wr(5'h11, 16'h0003);
    wr(5'h12, 16'h0040);
    event_in = 7'h40;
    tick(1);
    event_in = 7'h00;
    tick(2);
    chk(sleep_or_irq_pin_in, 1'h0);
    model[5'h12] = 16'h4040;
    rd(5'h11);
    rd(5'h12);
    model[5'h12] = 16'h0040;
    tick(3);
    chk(sleep_or_irq_pin_in, 1'h1);
    rd(5'h12);
    wr(5'h11, 16'h0007);
    tick(2);
    chk(sleep_or_irq_pin_in, 1'h0);
    rd(5'h11);
    model[5'h12] = 16'h4040;
    rd(5'h12);
    rd(5'h12);
    wr(5'h11, 16'h0000);
    pull_low = 1'h1;
    tick(3);
    chk(power_down, 1'h1);
    pull_low = 1'h0;
    rd(5'h03);
    rst = 1'h1;
    reduced_pin = 1'h1;
    rmii_mode = 1'h1;
    model.delete();
    tick(2);
    rst = 1'h0;
    wr(5'h11, 16'h0003);
    rd(5'h11);
    pull_low = 1'h1;
    tick(3);
    chk(power_down, 1'h0);
    wr(5'h1e, 16'h0001);
    tick(2);
    chk(power_down, 1'h1);
    ref_period(phy_power_pkg::clk_mhz / phy_power_pkg::rmii_ref_mhz);
    tick(100);
    summarize();
  end
endmodule
